// file: bench/comparator_event_shortcut_regs_tb.sv
// Self-checking testbench for the comparator event, link and interrupt mask register bank
module comparator_event_shortcut_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import comp_evt_pkg::*;

    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic start_task_i = 1'b0;
    logic stop_task_i = 1'b0;
    logic sample_task_i = 1'b0;
    // Comparator starts above threshold so the first crossing is downward
    logic comp_out_i = 1'b1;
    logic comp_valid_i = 1'b0;
    logic [31:0] rdata_o;
    logic sample_task_o, stop_task_o, running_o, result_o, irq_o;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;

    comp_event_regs u_comp_event_regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .start_task_i(start_task_i), .stop_task_i(stop_task_i), .sample_task_i(sample_task_i),
        .comp_out_i(comp_out_i), .comp_valid_i(comp_valid_i), .sample_task_o(sample_task_o),
        .stop_task_o(stop_task_o), .running_o(running_o), .result_o(result_o), .irq_o(irq_o));

    always #5 clk_i = ~clk_i;

    // Cycle ceiling well above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            $display("wrong value at %0t: run timed out", $time);
            results();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp, $sformatf("read %h", a));
    endtask

    task automatic tsk_pulse(input logic stop);
        @(posedge clk_i);
        if (stop) stop_task_i <= 1'b1;
        else start_task_i <= 1'b1;
        @(posedge clk_i);
        stop_task_i <= 1'b0;
        start_task_i <= 1'b0;
    endtask

    task automatic test_reset;
        rdchk(OFS_UP_FLAG, 32'h0);
        rdchk(OFS_CROSS_FLAG, 32'h0);
        rdchk(OFS_LINK_CFG, 32'h0);
        rdchk(OFS_IRQ_MASK, 32'h0);
        rdchk(OFS_RESULT, 32'h0);
        chk(irq_o, 32'h0, "irq after reset");
        $display("test reset done");
    endtask

    task automatic test_rw;
        wr(OFS_LINK_CFG, 32'hffff_ffff);
        rdchk(OFS_LINK_CFG, 32'h1f);
        @(posedge clk_i);
        #1;
        chk(rdata_o, 32'h0, "read data held too long");
        wr(OFS_IRQ_MASK, 32'hffff_ffff);
        rdchk(OFS_IRQ_MASK, 32'hf);
        chk(irq_o, 32'h0, "irq with no flag");
        wr(12'h7fc, 32'hffff_ffff);
        rdchk(12'h7fc, 32'h0);
        // Writing one to a flag word must not forge an event
        wr(OFS_UP_FLAG, 32'h1);
        rdchk(OFS_UP_FLAG, 32'h0);
        wr(OFS_IRQ_MASK, 32'h0);
        rdchk(OFS_IRQ_MASK, 32'h0);
        $display("test register access done");
    endtask

    task automatic test_ready;
        logic seen;
        logic st;
        seen = 1'b0;
        st = 1'b0;
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_LINK_CFG, 32'h3);
        tsk_pulse(1'b0);
        repeat (3) @(posedge clk_i);
        comp_valid_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            #1;
            if (sample_task_o === 1'b1) begin
                seen = 1'b1;
                st = stop_task_o;
                break;
            end
        end
        @(posedge clk_i);
        #1;
        chk(seen, 32'h1, "linked sample");
        chk(st, 32'h1, "linked stop on ready");
        chk(result_o, 32'h1, "latched decision");
        rdchk(OFS_RESULT, 32'h1);
        chk(running_o, 32'h0, "running after ready stop");
        chk(irq_o, 32'h1, "ready irq");
        rdchk(OFS_EVT_STATUS, 32'h1);
        wr(OFS_EVT_STATUS, 32'h1);
        #1;
        chk(irq_o, 32'h0, "irq after clear");
        $display("test ready done");
    endtask

    // One crossing while running; expected stop and interrupt follow from link and mask
    task automatic test_cross(input logic [31:0] link, input logic up, input logic [31:0] mask);
        logic fired;
        logic fire_exp;
        fired = 1'b0;
        fire_exp = link[4] | (up ? link[3] : link[2]);
        wr(OFS_LINK_CFG, link);
        wr(OFS_IRQ_MASK, mask);
        tsk_pulse(1'b0);
        repeat (3) @(posedge clk_i);
        comp_out_i <= up;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            #1;
            if (stop_task_o === 1'b1) begin
                fired = 1'b1;
                break;
            end
        end
        @(posedge clk_i);
        #1;
        chk(fired, fire_exp, "linked stop on crossing");
        chk(running_o, !fire_exp, "running after crossing");
        chk(irq_o, mask[3] | (up ? mask[2] : mask[1]), "crossing irq");
        rdchk(OFS_UP_FLAG, up);
        rdchk(OFS_CROSS_FLAG, 32'h1);
        wr(OFS_UP_FLAG, 32'h0);
        wr(OFS_CROSS_FLAG, 32'h0);
        wr(OFS_EVT_STATUS, 32'h2);
        rdchk(OFS_EVT_STATUS, 32'h0);
        chk(irq_o, 32'h0, "irq after flag clear");
        tsk_pulse(1'b1);
        $display("test crossing link %h up %0b mask %h done", link, up, mask);
    endtask

    // Software sample and stop pulses, and a stop that meets a start in one cycle
    task automatic test_sw_tasks;
        wr(OFS_LINK_CFG, 32'h0);
        comp_out_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        sample_task_i <= 1'b1;
        #1;
        chk(sample_task_o, 32'h1, "software sample");
        @(posedge clk_i);
        sample_task_i <= 1'b0;
        #1;
        chk(result_o, 32'h0, "sampled decision");
        rdchk(OFS_RESULT, 32'h0);
        tsk_pulse(1'b0);
        #1;
        chk(running_o, 32'h1, "running after start");
        tsk_pulse(1'b1);
        #1;
        chk(running_o, 32'h0, "running after software stop");
        @(posedge clk_i);
        start_task_i <= 1'b1;
        stop_task_i <= 1'b1;
        @(posedge clk_i);
        start_task_i <= 1'b0;
        stop_task_i <= 1'b0;
        #1;
        chk(running_o, 32'h0, "stop beats start");
        $display("test software tasks done");
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        test_reset();
        test_rw();
        test_ready();
        test_cross(32'h04, 1'b0, 32'h2);
        test_cross(32'h08, 1'b1, 32'h4);
        test_cross(32'h10, 1'b0, 32'h8);
        test_cross(32'h03, 1'b1, 32'h1);
        test_sw_tasks();
        results();
    end
endmodule

// file: src/comp_event_regs.sv
// Comparator event flags, event-to-task links, interrupt mask and register port
// Behaviour
// - Ready event triggers the sample task when the first link bit is set.
// - Ready event triggers the stop task when the second link bit is set.
// - Downward crossing triggers the stop task when the third link bit is set.
// - Upward crossing triggers the stop task when the fourth link bit is set.
// - Either-direction crossing triggers stop when fifth bit set; links reset to zero.
// - Ready event reaches the interrupt only while its mask bit is one.
// - Downward crossing interrupts only while its mask bit is one; bit read/write.
// - Upward crossing interrupts only while its mask bit is one.
// - Crossing interrupt gated by its mask bit; whole mask resets to zero.
// - Ready event fires once started and comparator output becomes valid.
// - Sample task, including the linked one, latches the comparator decision.
module comp_event_regs
    import comp_evt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic start_task_i,
    input wire logic stop_task_i,
    input wire logic sample_task_i,
    input wire logic comp_out_i,
    input wire logic comp_valid_i,
    output logic sample_task_o,
    output logic stop_task_o,
    output logic running_o,
    output logic result_o,
    output logic irq_o
);
    logic cmp_s1;
    logic cmp_s2;
    logic cmp_q;
    logic vld_s1;
    logic vld_s2;
    logic vld_q;
    run_state_t state;
    run_state_t next_state;
    logic [NUM_LK-1:0] event_task_link_cfg;
    logic [NUM_EV-1:0] irq_enable_mask;
    logic [NUM_EV-1:0] flags;
    logic [NUM_EV-1:0] evt;
    logic [NUM_EV-1:0] clr;
    logic [31:0] next_rdata;

    // Register address decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    wire wr_up = wr_i && hit(addr_i, OFS_UP_FLAG);
    wire wr_cross = wr_i && hit(addr_i, OFS_CROSS_FLAG);
    wire wr_status = wr_i && hit(addr_i, OFS_EVT_STATUS);
    wire wr_link = wr_i && hit(addr_i, OFS_LINK_CFG);
    wire wr_mask = wr_i && hit(addr_i, OFS_IRQ_MASK);
    wire run = (state == ST_RUN);

    // Both analog levels cross into the clock domain through two flops
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
            vld_s1 <= 1'b0;
            vld_s2 <= 1'b0;
        end else begin
            cmp_s1 <= comp_out_i;
            cmp_s2 <= cmp_s1;
            vld_s1 <= comp_valid_i;
            vld_s2 <= vld_s1;
        end
    end

    // Edge history taken only from the second synchroniser stage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmp_q <= 1'b0;
            vld_q <= 1'b0;
        end else begin
            cmp_q <= cmp_s2;
            vld_q <= vld_s2;
        end
    end

    // Event detection; crossings only count while running with a valid output
    assign evt[EV_READY] = run && vld_s2 && !vld_q;
    assign evt[EV_UP] = run && vld_s2 && vld_q && cmp_s2 && !cmp_q;
    assign evt[EV_DOWN] = run && vld_s2 && vld_q && !cmp_s2 && cmp_q;
    assign evt[EV_CROSS] = evt[EV_UP] || evt[EV_DOWN];

    // Task links: combinational so the task fires in the event's own cycle
    assign sample_task_o = sample_task_i
        || (evt[EV_READY] && event_task_link_cfg[LK_READY_SAMPLE]);
    assign stop_task_o = stop_task_i
        || (evt[EV_READY] && event_task_link_cfg[LK_READY_STOP])
        || (evt[EV_DOWN] && event_task_link_cfg[LK_DOWN_STOP])
        || (evt[EV_UP] && event_task_link_cfg[LK_UP_STOP])
        || (evt[EV_CROSS] && event_task_link_cfg[LK_EITHER_STOP]);

    // Run state; a stop in the same cycle as a start wins, leaving it idle
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_task_i && !stop_task_o) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_task_o) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end
    assign running_o = run;

    // Decision captured on every sample task
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            result_o <= RESULT_RST;
        end else if (sample_task_o) begin
            result_o <= cmp_s2;
        end
    end

    // Link field and interrupt mask, both cleared by reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            event_task_link_cfg <= LINK_CFG_RST;
            irq_enable_mask <= IRQ_MASK_RST;
        end else begin
            if (wr_link) begin
                event_task_link_cfg <= wdata_i[NUM_LK-1:0];
            end
            if (wr_mask) begin
                irq_enable_mask <= wdata_i[NUM_EV-1:0];
            end
        end
    end

    // Clears: writing 0 to a flag word, or writing 1 to a status bit
    assign clr[EV_READY] = wr_status && wdata_i[EV_READY];
    assign clr[EV_DOWN] = wr_status && wdata_i[EV_DOWN];
    assign clr[EV_UP] = (wr_up && !wdata_i[0]) || (wr_status && wdata_i[EV_UP]);
    assign clr[EV_CROSS] = (wr_cross && !wdata_i[0]) || (wr_status && wdata_i[EV_CROSS]);

    // One sticky flag per event
    genvar g;
    generate
        for (g = 0; g < NUM_EV; g++) begin : g_flag
            event_flag_cell u_flag (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .set_i(evt[g]),
                .clr_i(clr[g]),
                .flag_o(flags[g])
            );
        end
    endgenerate

    // Level interrupt while any enabled flag stands
    assign irq_o = |(flags & irq_enable_mask);

    // Word views of the two flags that have registers of their own
    wire upward_crossing_flag = flags[EV_UP];
    wire any_crossing_flag = flags[EV_CROSS];

    // Read mux; unmapped addresses read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit(addr_i, OFS_UP_FLAG)) begin
            next_rdata[0] = upward_crossing_flag;
        end else if (hit(addr_i, OFS_CROSS_FLAG)) begin
            next_rdata[0] = any_crossing_flag;
        end else if (hit(addr_i, OFS_EVT_STATUS)) begin
            next_rdata[NUM_EV-1:0] = flags;
        end else if (hit(addr_i, OFS_LINK_CFG)) begin
            next_rdata[NUM_LK-1:0] = event_task_link_cfg;
        end else if (hit(addr_i, OFS_IRQ_MASK)) begin
            next_rdata[NUM_EV-1:0] = irq_enable_mask;
        end else if (hit(addr_i, OFS_RESULT)) begin
            next_rdata[0] = result_o;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    // Checks on the links, mask, flags and result capture
    property p_ready_sample;
        @(posedge clk_i) disable iff (!rst_n_i)
        evt[EV_READY] && event_task_link_cfg[LK_READY_SAMPLE] |-> sample_task_o;
    endproperty
    a_ready_sample: assert property (p_ready_sample) else $error("ready link no sample");

    property p_ready_stop;
        @(posedge clk_i) disable iff (!rst_n_i)
        evt[EV_READY] && event_task_link_cfg[LK_READY_STOP] |-> stop_task_o ##1 !running_o;
    endproperty
    a_ready_stop: assert property (p_ready_stop) else $error("ready link no stop");

    property p_down_stop;
        @(posedge clk_i) disable iff (!rst_n_i)
        evt[EV_DOWN] && event_task_link_cfg[LK_DOWN_STOP] |=> !running_o;
    endproperty
    a_down_stop: assert property (p_down_stop) else $error("down link no stop");

    property p_up_stop;
        @(posedge clk_i) disable iff (!rst_n_i)
        evt[EV_UP] && event_task_link_cfg[LK_UP_STOP] |=> !running_o;
    endproperty
    a_up_stop: assert property (p_up_stop) else $error("up link no stop");

    property p_no_spurious_stop;
        @(posedge clk_i) disable iff (!rst_n_i)
        stop_task_o && !stop_task_i |-> |(event_task_link_cfg);
    endproperty
    a_no_spurious_stop: assert property (p_no_spurious_stop) else $error("stop w/o link");

    property p_link_reset;
        @(posedge clk_i) $rose(rst_n_i) |-> event_task_link_cfg == LINK_CFG_RST;
    endproperty
    a_link_reset: assert property (p_link_reset) else $error("links not reset");

    property p_ready_irq;
        @(posedge clk_i) disable iff (!rst_n_i)
        evt[EV_READY] && irq_enable_mask[EV_READY] && !wr_mask |=> irq_o;
    endproperty
    a_ready_irq: assert property (p_ready_irq) else $error("ready irq missing");

    property p_mask_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_mask |=> irq_enable_mask == $past(wdata_i[NUM_EV-1:0]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask not written");

    property p_up_irq;
        @(posedge clk_i) disable iff (!rst_n_i)
        evt[EV_UP] && irq_enable_mask[EV_UP] && !wr_mask |=> irq_o;
    endproperty
    a_up_irq: assert property (p_up_irq) else $error("up irq missing");

    property p_mask_reset;
        @(posedge clk_i) $rose(rst_n_i) |-> irq_enable_mask == IRQ_MASK_RST && !irq_o;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask not reset");

    property p_ready_event;
        @(posedge clk_i) disable iff (!rst_n_i)
        run && $rose(vld_s2) |=> flags[EV_READY];
    endproperty
    a_ready_event: assert property (p_ready_event) else $error("ready not flagged");

    property p_sample_latch;
        @(posedge clk_i) disable iff (!rst_n_i)
        sample_task_o |=> result_o == $past(cmp_s2);
    endproperty
    a_sample_latch: assert property (p_sample_latch) else $error("result not latched");

    property p_set_wins;
        @(posedge clk_i) disable iff (!rst_n_i)
        evt[EV_UP] |=> flags[EV_UP] && flags[EV_CROSS];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("up flag lost");

    property p_cross_clear;
        @(posedge clk_i) disable iff (!rst_n_i)
        clr[EV_CROSS] && !evt[EV_CROSS] |=> !flags[EV_CROSS];
    endproperty
    a_cross_clear: assert property (p_cross_clear) else $error("cross flag not cleared");

    // Covers for linked and software tasks, a stop meeting a start, and the interrupt
    c_linked_sample: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        evt[EV_READY] && event_task_link_cfg[LK_READY_SAMPLE]);
    c_either_to_halt_link: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        evt[EV_CROSS] && event_task_link_cfg[LK_EITHER_STOP]);
    c_sw_sample: cover property (@(posedge clk_i) disable iff (!rst_n_i) sample_task_i);
    c_stop_beats_start: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        !run && start_task_i && stop_task_i);
    c_irq: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(irq_o));
endmodule

// file: src/comp_evt_pkg.sv
// Register map, field positions and reset values for the comparator event register bank
package comp_evt_pkg;
    localparam logic [11:0] OFS_UP_FLAG = 12'h108;
    localparam logic [11:0] OFS_CROSS_FLAG = 12'h10c;
    localparam logic [11:0] OFS_EVT_STATUS = 12'h110;
    localparam logic [11:0] OFS_LINK_CFG = 12'h200;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h300;
    localparam logic [11:0] OFS_RESULT = 12'h400;
    // Bit positions shared by the status and mask layouts
    localparam int EV_READY = 0;
    localparam int EV_DOWN = 1;
    localparam int EV_UP = 2;
    localparam int EV_CROSS = 3;
    localparam int NUM_EV = 4;
    // Bit positions of the event-to-task link field
    localparam int LK_READY_SAMPLE = 0;
    localparam int LK_READY_STOP = 1;
    localparam int LK_DOWN_STOP = 2;
    localparam int LK_UP_STOP = 3;
    localparam int LK_EITHER_STOP = 4;
    localparam int NUM_LK = 5;
    localparam logic [4:0] LINK_CFG_RST = 5'h00;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    localparam logic RESULT_RST = 1'h0;
    typedef enum logic {ST_IDLE, ST_RUN} run_state_t;
endpackage

// file: src/event_flag_cell.sv
// One sticky event flag where a hardware set always beats a software clear
module event_flag_cell (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    // Set is checked first so an event in the clearing cycle is kept
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end
endmodule
